// [design/dcr_config_regs.sv]
// Timing configuration register bank for the two channels and their dividers.
//
// Contract
// (R1) Blanking bit 7 (channel 2) and bit 6 (channel 1) pick short blanking at 0, long at 1.
// (R2) Filter select bits 3 (channel 2) and 0 (channel 1); other blanking bits are reserved.
// (R3) Channel clock is main clock divided by 2, 4, 8, 8 for codes 00..11, bits 3:2 and 1:0.
// (R4) A 3-bit slope code per channel sets the ramp peak in 50 mV steps from 0 to 350 mV.
// (R5) Spread magnitude 00 disables modulation, 01/10/11 give 3.75, 7.5 and 15 percent.
// (R6) Spread rate codes 0..13 divide the main clock by 4096 down to 8; 14 and 15 disable.
// (R7) Ramp code 0 disables soft-start, codes 1..15 divide its clock by 2 up to 100.
// (R8) In dual phase only the channel 1 ramp and current values drive both channels.
// (R9) A channel is held off while its current code is 8 or below.
// (R10) Current codes 9 to 255 span 85 mV to 2.4 V at the converter.
// (R11) The PWM clock is the main clock divided by the 3-bit code plus one.
// (R12) The low width register gives the eight low bits of the 10-bit width.
// (R13) Bits 1:0 of the high width register give width bits 9:8; bits 7:2 are reserved.
// (R14) Dual-phase select 0 is two independent channels, 1 is dual phase.
// (R15) Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
module dcr_config_regs (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic dual_phase_select,
  output logic ch1_edge_blank_length,
  output logic ch2_edge_blank_length,
  output logic ch1_limit_comparator_filter,
  output logic ch2_limit_comparator_filter,
  output logic ch1_channel_clock,
  output logic ch2_channel_clock,
  output logic [2:0] ch1_slope_comp_level,
  output logic [2:0] ch2_slope_comp_level,
  output logic [1:0] spread_magnitude,
  output logic spread_active,
  output logic spread_rate_tick,
  output logic ch1_ramp_clock,
  output logic ch2_ramp_clock,
  output logic [7:0] ch1_current_dac_code,
  output logic [7:0] ch2_current_dac_code,
  output logic ch1_channel_off,
  output logic ch2_channel_off,
  output logic pwm_clock_tick,
  output logic [9:0] ch1_pwm_width,
  output logic [9:0] ch2_pwm_width
);

  typedef struct packed {
    logic [7:0] blank;
    logic [7:0] clkdiv;
    logic [7:0] slope;
    logic [7:0] spread;
    logic [7:0] ramp;
    logic [7:0] cur1;
    logic [7:0] cur2;
    logic [7:0] pwm_clock_divide;
    logic [7:0] w1lo;
    logic [7:0] w1hi;
    logic [7:0] w2lo;
    logic [7:0] w2hi;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] leb;
    logic [1:0] filt;
    logic [2:0] slp1;
    logic [2:0] slp2;
    logic [1:0] mag;
    logic spr_on;
    logic [7:0] dac1;
    logic [7:0] dac2;
    logic [1:0] off;
    logic [9:0] pw1;
    logic [9:0] pw2;
  } dcr_state_t;

  // Outputs at reset already agree with the register reset values.
  localparam dcr_state_t ST_RESET = '{
    blank: dcr_pkg::RST_BLANK_FILTER,
    clkdiv: dcr_pkg::RST_CHAN_CLK_DIV,
    slope: dcr_pkg::RST_SLOPE_LEVEL,
    spread: dcr_pkg::RST_SPREAD_CFG,
    ramp: dcr_pkg::RST_RAMP_CLK_DIV,
    cur1: dcr_pkg::RST_CURRENT,
    cur2: dcr_pkg::RST_CURRENT,
    pwm_clock_divide: dcr_pkg::RST_PWM_CLK_DIV,
    w1lo: dcr_pkg::RST_WIDTH,
    w1hi: dcr_pkg::RST_WIDTH,
    w2lo: dcr_pkg::RST_WIDTH,
    w2hi: dcr_pkg::RST_WIDTH,
    slp1: dcr_pkg::RST_SLOPE_LEVEL[dcr_pkg::SLOPE_CH1_LSB +: 3],
    slp2: dcr_pkg::RST_SLOPE_LEVEL[dcr_pkg::SLOPE_CH2_LSB +: 3],
    mag: dcr_pkg::RST_SPREAD_CFG[dcr_pkg::SPREAD_MAG_LSB +: 2],
    off: 2'h3,
    default: '0
  };

  dcr_state_t st_ff;
  dcr_state_t nxt_st;

  dcr_div_if ch1_clk_if ();
  dcr_div_if ch2_clk_if ();
  dcr_div_if ramp1_if ();
  dcr_div_if ramp2_if ();
  dcr_div_if spread_if ();
  dcr_div_if pwm_if ();

  logic [3:0] ramp2_code;
  logic [3:0] spread_rate;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        dcr_pkg::ADDR_BLANK_FILTER: nxt_st.blank = reg_wdata & dcr_pkg::MASK_BLANK_FILTER; // R15
        dcr_pkg::ADDR_CHAN_CLK_DIV: nxt_st.clkdiv = reg_wdata & dcr_pkg::MASK_CHAN_CLK_DIV; // R15
        dcr_pkg::ADDR_SLOPE_LEVEL: nxt_st.slope = reg_wdata & dcr_pkg::MASK_SLOPE_LEVEL; // R15
        dcr_pkg::ADDR_SPREAD_CFG: nxt_st.spread = reg_wdata & dcr_pkg::MASK_SPREAD_CFG; // R15
        dcr_pkg::ADDR_RAMP_CLK_DIV: nxt_st.ramp = reg_wdata & dcr_pkg::MASK_FULL;
        dcr_pkg::ADDR_CH1_CURRENT: nxt_st.cur1 = reg_wdata & dcr_pkg::MASK_FULL;
        dcr_pkg::ADDR_CH2_CURRENT: nxt_st.cur2 = reg_wdata & dcr_pkg::MASK_FULL;
        dcr_pkg::ADDR_PWM_CLK_DIV: nxt_st.pwm_clock_divide = reg_wdata & dcr_pkg::MASK_PWM_CLK_DIV; // R15
        dcr_pkg::ADDR_CH1_WIDTH_LO: nxt_st.w1lo = reg_wdata & dcr_pkg::MASK_FULL;
        dcr_pkg::ADDR_CH1_WIDTH_HI: nxt_st.w1hi = reg_wdata & dcr_pkg::MASK_WIDTH_HI; // R13
        dcr_pkg::ADDR_CH2_WIDTH_LO: nxt_st.w2lo = reg_wdata & dcr_pkg::MASK_FULL;
        dcr_pkg::ADDR_CH2_WIDTH_HI: nxt_st.w2hi = reg_wdata & dcr_pkg::MASK_WIDTH_HI; // R13
        default: ;
      endcase
    end
    // A read in the same cycle as a write returns the value before the write.
    if (reg_rd) begin
      nxt_st.rvalid = 1'b1;
      case (reg_addr)
        dcr_pkg::ADDR_BLANK_FILTER: nxt_st.rdata = st_ff.blank;
        dcr_pkg::ADDR_CHAN_CLK_DIV: nxt_st.rdata = st_ff.clkdiv;
        dcr_pkg::ADDR_SLOPE_LEVEL: nxt_st.rdata = st_ff.slope;
        dcr_pkg::ADDR_SPREAD_CFG: nxt_st.rdata = st_ff.spread;
        dcr_pkg::ADDR_RAMP_CLK_DIV: nxt_st.rdata = st_ff.ramp;
        dcr_pkg::ADDR_CH1_CURRENT: nxt_st.rdata = st_ff.cur1;
        dcr_pkg::ADDR_CH2_CURRENT: nxt_st.rdata = st_ff.cur2;
        dcr_pkg::ADDR_PWM_CLK_DIV: nxt_st.rdata = st_ff.pwm_clock_divide;
        dcr_pkg::ADDR_CH1_WIDTH_LO: nxt_st.rdata = st_ff.w1lo;
        dcr_pkg::ADDR_CH1_WIDTH_HI: nxt_st.rdata = st_ff.w1hi;
        dcr_pkg::ADDR_CH2_WIDTH_LO: nxt_st.rdata = st_ff.w2lo;
        dcr_pkg::ADDR_CH2_WIDTH_HI: nxt_st.rdata = st_ff.w2hi;
        default: nxt_st.rdata = '0;
      endcase
    end
    nxt_st.leb[1] = nxt_st.blank[dcr_pkg::BIT_CH2_BLANK]; // R1
    nxt_st.leb[0] = nxt_st.blank[dcr_pkg::BIT_CH1_BLANK]; // R1
    nxt_st.filt[1] = nxt_st.blank[dcr_pkg::BIT_CH2_FILTER]; // R2
    nxt_st.filt[0] = nxt_st.blank[dcr_pkg::BIT_CH1_FILTER]; // R2
    nxt_st.slp1 = nxt_st.slope[dcr_pkg::SLOPE_CH1_LSB +: 3]; // R4
    nxt_st.slp2 = nxt_st.slope[dcr_pkg::SLOPE_CH2_LSB +: 3]; // R4
    nxt_st.mag = nxt_st.spread[dcr_pkg::SPREAD_MAG_LSB +: 2]; // R5
    nxt_st.spr_on = (nxt_st.mag != dcr_pkg::SPREAD_MAG_OFF) // R5
      && (nxt_st.spread[dcr_pkg::SPREAD_RATE_LSB +: 4] < dcr_pkg::SPREAD_RATE_OFF_MIN); // R6
    nxt_st.dac1 = nxt_st.cur1; // R10
    nxt_st.dac2 = dual_phase_select ? nxt_st.cur1 : nxt_st.cur2; // R8 R14
    nxt_st.off[0] = nxt_st.dac1 <= dcr_pkg::CURRENT_OFF_MAX; // R9
    nxt_st.off[1] = nxt_st.dac2 <= dcr_pkg::CURRENT_OFF_MAX; // R9
    nxt_st.pw1 = {nxt_st.w1hi[dcr_pkg::WIDTH_HI_LSB +: 2], nxt_st.w1lo}; // R12 R13
    nxt_st.pw2 = {nxt_st.w2hi[dcr_pkg::WIDTH_HI_LSB +: 2], nxt_st.w2lo}; // R12 R13
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Dividers see the stored codes, so a new code takes hold one clock after its write.
  assign ramp2_code = dual_phase_select ? st_ff.ramp[dcr_pkg::RAMP_CH1_LSB +: 4]
                                        : st_ff.ramp[dcr_pkg::RAMP_CH2_LSB +: 4]; // R8
  assign spread_rate = st_ff.spread[dcr_pkg::SPREAD_RATE_LSB +: 4];
  assign ch1_clk_if.ratio = dcr_pkg::chan_ratio(st_ff.clkdiv[dcr_pkg::CLKDIV_CH1_LSB +: 2]); // R3
  assign ch2_clk_if.ratio = dcr_pkg::chan_ratio(st_ff.clkdiv[dcr_pkg::CLKDIV_CH2_LSB +: 2]); // R3
  assign ramp1_if.ratio = dcr_pkg::ramp_ratio(st_ff.ramp[dcr_pkg::RAMP_CH1_LSB +: 4]); // R7
  assign ramp2_if.ratio = dcr_pkg::ramp_ratio(ramp2_code); // R7
  assign spread_if.ratio = (st_ff.mag == dcr_pkg::SPREAD_MAG_OFF)
    ? '0 : dcr_pkg::spread_ratio(spread_rate); // R5 R6
  assign pwm_if.ratio = {{(dcr_pkg::DIV_W - 3){1'b0}}, st_ff.pwm_clock_divide[2:0]} + 1'b1; // R11

  dcr_tick_div u_ch1_clk (.mclk(mclk), .rst_n(rst_n), .dv(ch1_clk_if));
  dcr_tick_div u_ch2_clk (.mclk(mclk), .rst_n(rst_n), .dv(ch2_clk_if));
  dcr_tick_div u_ramp1 (.mclk(mclk), .rst_n(rst_n), .dv(ramp1_if));
  dcr_tick_div u_ramp2 (.mclk(mclk), .rst_n(rst_n), .dv(ramp2_if));
  dcr_tick_div u_spread (.mclk(mclk), .rst_n(rst_n), .dv(spread_if));
  dcr_tick_div u_pwm (.mclk(mclk), .rst_n(rst_n), .dv(pwm_if));

  assign reg_rdata = st_ff.rdata;
  assign reg_rvalid = st_ff.rvalid;
  assign ch1_edge_blank_length = st_ff.leb[0];
  assign ch2_edge_blank_length = st_ff.leb[1];
  assign ch1_limit_comparator_filter = st_ff.filt[0];
  assign ch2_limit_comparator_filter = st_ff.filt[1];
  assign ch1_channel_clock = ch1_clk_if.tick;
  assign ch2_channel_clock = ch2_clk_if.tick;
  assign ch1_slope_comp_level = st_ff.slp1;
  assign ch2_slope_comp_level = st_ff.slp2;
  assign spread_magnitude = st_ff.mag;
  assign spread_active = st_ff.spr_on;
  assign spread_rate_tick = spread_if.tick;
  assign ch1_ramp_clock = ramp1_if.tick;
  assign ch2_ramp_clock = ramp2_if.tick;
  assign ch1_current_dac_code = st_ff.dac1;
  assign ch2_current_dac_code = st_ff.dac2;
  assign ch1_channel_off = st_ff.off[0];
  assign ch2_channel_off = st_ff.off[1];
  assign pwm_clock_tick = pwm_if.tick;
  assign ch1_pwm_width = st_ff.pw1;
  assign ch2_pwm_width = st_ff.pw2;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic ch1_div2;
  logic pwm_div1;
  assign ch1_div2 = st_ff.clkdiv[dcr_pkg::CLKDIV_CH1_LSB +: 2] == 2'h0;
  assign pwm_div1 = st_ff.pwm_clock_divide[2:0] == 3'h0;

  sequence blank_write_s;
    reg_wr && reg_addr == dcr_pkg::ADDR_BLANK_FILTER;
  endsequence

  sequence ch1_div2_hold_s;
    (ch1_channel_clock && ch1_div2) ##1 ch1_div2 [*2];
  endsequence

  // A zero ratio one cycle earlier must already have stopped the divider.
  sequence spread_idle_s;
    $past(st_ff.mag) == dcr_pkg::SPREAD_MAG_OFF
      || $past(spread_rate) >= dcr_pkg::SPREAD_RATE_OFF_MIN;
  endsequence

  sequence cur1_write_s;
    reg_wr && reg_addr == dcr_pkg::ADDR_CH1_CURRENT;
  endsequence

  blank_length_a: assert property (blank_write_s |=> // R1
    ch2_edge_blank_length == $past(reg_wdata[7]) && ch1_edge_blank_length == $past(reg_wdata[6]))
    else $error("Blanking length does not follow the written bits.");

  filter_select_a: assert property (blank_write_s |=> // R2
    ch2_limit_comparator_filter == $past(reg_wdata[3])
    && ch1_limit_comparator_filter == $past(reg_wdata[0]))
    else $error("Filter select does not follow the written bits.");

  reserved_zero_a: assert property (reg_rd && reg_addr == dcr_pkg::ADDR_CH1_WIDTH_HI |=> // R15
    reg_rvalid && reg_rdata[7:2] == 6'h00)
    else $error("Reserved width bits read as nonzero.");

  chan_div_a: assert property (ch1_div2_hold_s |-> // R3
    ch1_channel_clock && !$past(ch1_channel_clock))
    else $error("Channel clock does not divide by two.");

  slope_code_a: assert property (reg_wr && reg_addr == dcr_pkg::ADDR_SLOPE_LEVEL |=> // R4
    ch1_slope_comp_level == $past(reg_wdata[2:0]) && ch2_slope_comp_level == $past(reg_wdata[6:4]))
    else $error("Slope level does not follow the written code.");

  spread_off_a: assert property (spread_idle_s |-> !spread_rate_tick) // R5 R6
    else $error("Spread tick while modulation is disabled.");

  ramp_off_a: assert property ($past(st_ff.ramp[3:0]) == 4'h0 |-> !ch1_ramp_clock) // R7
    else $error("Ramp clock runs while soft-start is disabled.");

  dual_phase_a: assert property (dual_phase_select |=> // R8 R14
    ch2_current_dac_code == st_ff.cur1)
    else $error("Dual phase does not copy the channel 1 current code.");

  single_phase_a: assert property (!dual_phase_select |=> // R14 R10
    ch2_current_dac_code == st_ff.cur2 && ch1_current_dac_code == st_ff.cur1)
    else $error("Current code does not follow its register.");

  chan_off_a: assert property ((ch2_current_dac_code <= 8'h08) == ch2_channel_off) // R9
    else $error("Channel off does not match the current code.");

  pwm_div_a: assert property (pwm_div1 ##1 pwm_div1 |-> pwm_clock_tick) // R11
    else $error("PWM clock does not run at divide by one.");

  pwm_width_a: assert property (ch1_pwm_width == {st_ff.w1hi[1:0], st_ff.w1lo}) // R12 R13
    else $error("PWM width does not join its two registers.");

  width_join_a: assert property ( // R12 R13
    ch2_pwm_width == {st_ff.w2hi[dcr_pkg::WIDTH_HI_LSB +: 2], st_ff.w2lo})
    else $error("Channel 2 PWM width does not join its two registers.");

  ch1_off_a: assert property ( // R9
    (ch1_current_dac_code <= dcr_pkg::CURRENT_OFF_MAX) == ch1_channel_off)
    else $error("Channel 1 off does not match its current code.");

  current_code_a: assert property (cur1_write_s |=> // R10
    ch1_current_dac_code == $past(reg_wdata))
    else $error("Channel 1 current code does not follow its write.");

  blank_reserved_a: assert property (blank_write_s |=> // R15
    (st_ff.blank & ~dcr_pkg::MASK_BLANK_FILTER) == 8'h00)
    else $error("Reserved blanking bits took a written value.");

  // In dual phase the channel 2 ramp divider runs from the channel 1 code.
  ramp2_off_a: assert property ( // R7 R8
    $past(ramp2_code) == dcr_pkg::RAMP_CODE_OFF |-> !ch2_ramp_clock)
    else $error("Channel 2 ramp clock runs while its code is off.");

  spread_on_a: assert property ( // R5 R6
    spread_active == (spread_magnitude != dcr_pkg::SPREAD_MAG_OFF
      && spread_rate < dcr_pkg::SPREAD_RATE_OFF_MIN))
    else $error("Spread enable does not match magnitude and rate.");

endmodule : dcr_config_regs

// [pkg/dcr_pkg.sv]
// Register map, reset values, field layout and divider tables of the timing config bank.
package dcr_pkg;

  localparam int unsigned DIV_W = 13;

  localparam logic [7:0] ADDR_BLANK_FILTER = 8'h02;
  localparam logic [7:0] ADDR_CHAN_CLK_DIV = 8'h03;
  localparam logic [7:0] ADDR_SLOPE_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_SPREAD_CFG = 8'h05;
  localparam logic [7:0] ADDR_RAMP_CLK_DIV = 8'h06;
  localparam logic [7:0] ADDR_CH1_CURRENT = 8'h07;
  localparam logic [7:0] ADDR_CH2_CURRENT = 8'h08;
  localparam logic [7:0] ADDR_PWM_CLK_DIV = 8'h09;
  localparam logic [7:0] ADDR_CH1_WIDTH_LO = 8'h0a;
  localparam logic [7:0] ADDR_CH1_WIDTH_HI = 8'h0b;
  localparam logic [7:0] ADDR_CH2_WIDTH_LO = 8'h0c;
  localparam logic [7:0] ADDR_CH2_WIDTH_HI = 8'h0d;

  localparam logic [7:0] RST_BLANK_FILTER = 8'h00;
  localparam logic [7:0] RST_CHAN_CLK_DIV = 8'h00;
  localparam logic [7:0] RST_SLOPE_LEVEL = 8'h55;
  localparam logic [7:0] RST_SPREAD_CFG = 8'h05;
  localparam logic [7:0] RST_RAMP_CLK_DIV = 8'h77;
  localparam logic [7:0] RST_CURRENT = 8'h00;
  localparam logic [7:0] RST_PWM_CLK_DIV = 8'h01;
  localparam logic [7:0] RST_WIDTH = 8'h00;

  // Writable bits of each register; all other bits are reserved.
  localparam logic [7:0] MASK_BLANK_FILTER = 8'hc9;
  localparam logic [7:0] MASK_CHAN_CLK_DIV = 8'h0f;
  localparam logic [7:0] MASK_SLOPE_LEVEL = 8'h77;
  localparam logic [7:0] MASK_SPREAD_CFG = 8'h3f;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_PWM_CLK_DIV = 8'h07;
  localparam logic [7:0] MASK_WIDTH_HI = 8'h03;

  localparam int unsigned BIT_CH2_BLANK = 7;
  localparam int unsigned BIT_CH1_BLANK = 6;
  localparam int unsigned BIT_CH2_FILTER = 3;
  localparam int unsigned BIT_CH1_FILTER = 0;
  localparam int unsigned CLKDIV_CH2_LSB = 2;
  localparam int unsigned CLKDIV_CH1_LSB = 0;
  localparam int unsigned SLOPE_CH2_LSB = 4;
  localparam int unsigned SLOPE_CH1_LSB = 0;
  localparam int unsigned SPREAD_MAG_LSB = 4;
  localparam int unsigned SPREAD_RATE_LSB = 0;
  localparam int unsigned RAMP_CH2_LSB = 4;
  localparam int unsigned RAMP_CH1_LSB = 0;
  localparam int unsigned WIDTH_HI_LSB = 0;

  localparam logic [7:0] CURRENT_OFF_MAX = 8'h08;
  localparam logic [1:0] SPREAD_MAG_OFF = 2'h0;
  localparam logic [3:0] SPREAD_RATE_OFF_MIN = 4'he;
  localparam logic [3:0] RAMP_CODE_OFF = 4'h0;

  function automatic logic [DIV_W-1:0] chan_ratio(input logic [1:0] code);
    case (code)
      2'h0: chan_ratio = 13'h0002;
      2'h1: chan_ratio = 13'h0004;
      default: chan_ratio = 13'h0008;
    endcase
  endfunction : chan_ratio

  function automatic logic [DIV_W-1:0] ramp_ratio(input logic [3:0] code);
    case (code)
      4'h1: ramp_ratio = 13'h0002;
      4'h2: ramp_ratio = 13'h0004;
      4'h3: ramp_ratio = 13'h0006;
      4'h4: ramp_ratio = 13'h0008;
      4'h5: ramp_ratio = 13'h000c;
      4'h6: ramp_ratio = 13'h0010;
      4'h7: ramp_ratio = 13'h0014;
      4'h8: ramp_ratio = 13'h001a;
      4'h9: ramp_ratio = 13'h0020;
      4'ha: ramp_ratio = 13'h0026;
      4'hb: ramp_ratio = 13'h002e;
      4'hc: ramp_ratio = 13'h0036;
      4'hd: ramp_ratio = 13'h0040;
      4'he: ramp_ratio = 13'h0050;
      4'hf: ramp_ratio = 13'h0064;
      default: ramp_ratio = 13'h0000;
    endcase
  endfunction : ramp_ratio

  function automatic logic [DIV_W-1:0] spread_ratio(input logic [3:0] code);
    case (code)
      4'h0: spread_ratio = 13'h1000;
      4'h1: spread_ratio = 13'h0e00;
      4'h2: spread_ratio = 13'h0c00;
      4'h3: spread_ratio = 13'h0a00;
      4'h4: spread_ratio = 13'h0800;
      4'h5: spread_ratio = 13'h0600;
      4'h6: spread_ratio = 13'h0400;
      4'h7: spread_ratio = 13'h0200;
      4'h8: spread_ratio = 13'h0100;
      4'h9: spread_ratio = 13'h0080;
      4'ha: spread_ratio = 13'h0040;
      4'hb: spread_ratio = 13'h0020;
      4'hc: spread_ratio = 13'h0010;
      4'hd: spread_ratio = 13'h0008;
      default: spread_ratio = 13'h0000;
    endcase
  endfunction : spread_ratio

endpackage : dcr_pkg

// [pkg/dcr_div_if.sv]
// Ratio and tick pair between the register bank and one divider.
`timescale 1ns/1ps
interface dcr_div_if;
  logic [dcr_pkg::DIV_W-1:0] ratio;
  logic tick;
  modport divider(input ratio, output tick);
  modport user(output ratio, input tick);
endinterface : dcr_div_if

// [design/dcr_tick_div.sv]
// Programmable divider that pulses once every ratio clocks; ratio zero stops it.
`timescale 1ns/1ps
module dcr_tick_div (
  input wire logic mclk,
  input wire logic rst_n,
  dcr_div_if.divider dv
);

  typedef struct packed {
    logic [dcr_pkg::DIV_W-1:0] cnt;
    logic tick;
  } dcr_div_state_t;

  dcr_div_state_t st_ff;
  dcr_div_state_t nxt_st;

  // A ratio that shrinks below the running count ends the period at once.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (dv.ratio == '0) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= dv.ratio - 1'b1) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dv.tick = st_ff.tick;

endmodule : dcr_tick_div

// [tb/dcr_config_regs_tb.sv]
// Self-checking testbench for the timing configuration register bank.
`timescale 1ns/1ps
module dcr_config_regs_tb;
  logic mclk;
  logic rst_n;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic dual_phase_select;
  logic ch1_blank, ch2_blank, ch1_filt, ch2_filt;
  logic ch1_cclk, ch2_cclk, ch1_rclk, ch2_rclk;
  logic [2:0] ch1_slope, ch2_slope;
  logic [1:0] spread_magnitude;
  logic spread_active, spread_rate_tick, pwm_clock_tick;
  logic [7:0] ch1_code, ch2_code;
  logic ch1_off, ch2_off;
  logic [9:0] ch1_width, ch2_width;
  int errors = 0;
  int check_count = 0;
  // Reset values and writable-bit masks of addresses 0x02 to 0x0d in order.
  logic [7:0] rst_tab [12] = '{8'h00, 8'h00, 8'h55, 8'h05, 8'h77, 8'h00, 8'h00, 8'h01,
                               8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] mask_tab [12] = '{8'hc9, 8'h0f, 8'h77, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h07,
                                8'hff, 8'h03, 8'hff, 8'h03};
  logic [7:0] ramp_tab [15] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1a,
                                8'h20, 8'h26, 8'h2e, 8'h36, 8'h40, 8'h50, 8'h64};
  logic [7:0] bf_tab [4] = '{8'h80, 8'h40, 8'h08, 8'h01};
  logic [7:0] cur_tab [4] = '{8'h00, 8'h08, 8'h09, 8'hff};

  dcr_config_regs uut (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .dual_phase_select(dual_phase_select),
    .ch1_edge_blank_length(ch1_blank), .ch2_edge_blank_length(ch2_blank),
    .ch1_limit_comparator_filter(ch1_filt), .ch2_limit_comparator_filter(ch2_filt),
    .ch1_channel_clock(ch1_cclk), .ch2_channel_clock(ch2_cclk),
    .ch1_slope_comp_level(ch1_slope), .ch2_slope_comp_level(ch2_slope),
    .spread_magnitude(spread_magnitude), .spread_active(spread_active),
    .spread_rate_tick(spread_rate_tick), .ch1_ramp_clock(ch1_rclk), .ch2_ramp_clock(ch2_rclk),
    .ch1_current_dac_code(ch1_code), .ch2_current_dac_code(ch2_code),
    .ch1_channel_off(ch1_off), .ch2_channel_off(ch2_off), .pwm_clock_tick(pwm_clock_tick),
    .ch1_pwm_width(ch1_width), .ch2_pwm_width(ch2_width)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic conclude();
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Inputs always move 5 ns after the rising edge, well clear of sampling.
  task automatic step();
    @(posedge mclk);
    #5;
  endtask : step

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    step();
    reg_wr = 1'b0;
    step();
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    reg_rd = 1'b1;
    reg_addr = addr;
    step();
    reg_rd = 1'b0;
    check(16'(reg_rvalid), 16'h0001);
    check(16'(reg_rdata), 16'(exp));
    step();
    check(16'(reg_rvalid), 16'h0000);
  endtask : rd

  function automatic logic tick(input int s);
    case (s)
      0: tick = ch1_cclk;
      1: tick = ch2_cclk;
      2: tick = spread_rate_tick;
      3: tick = ch1_rclk;
      4: tick = ch2_rclk;
      default: tick = pwm_clock_tick;
    endcase
  endfunction : tick

  // The first tick after a ratio change may come early, so timing starts from it.
  task automatic period(input int s, input int exp);
    int n;
    n = 0;
    while (tick(s) !== 1'b1 && n < 5000) begin
      step();
      n++;
    end
    n = 0;
    do begin
      step();
      n++;
    end while (tick(s) !== 1'b1 && n < 5000);
    check(16'(n), 16'(exp));
  endtask : period

  task automatic no_ticks(input int s);
    int n;
    n = 0;
    for (int i = 0; i < 300; i++) begin
      step();
      if (tick(s) !== 1'b0) n++;
    end
    check(16'(n), 16'h0000);
  endtask : no_ticks

  initial begin
    #(60000 * 50);
    errors++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    dual_phase_select = 1'b0;
    repeat (10) @(posedge mclk);
    #5;
    rst_n = 1'b1;
    check(16'({ch2_slope, ch1_slope}), 16'h002d);
    check(16'({ch2_off, ch1_off, spread_active}), 16'h0006);
    check(16'(ch1_width), 16'h0000);
    check(16'(ch2_width), 16'h0000);
    for (int i = 0; i < 12; i++) rd(8'h02 + 8'(i), rst_tab[i]);
    for (int i = 0; i < 12; i++) begin
      wr(8'h02 + 8'(i), 8'hff);
      rd(8'h02 + 8'(i), mask_tab[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h02, bf_tab[i]);
      check(16'({ch2_blank, ch1_blank, ch2_filt, ch1_filt}),
            16'({bf_tab[i][7], bf_tab[i][6], bf_tab[i][3], bf_tab[i][0]}));
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h03, {4'h0, 2'(c), 2'(c)});
      period(0, (c == 0) ? 2 : (c == 1) ? 4 : 8);
      period(1, (c == 0) ? 2 : (c == 1) ? 4 : 8);
    end
    wr(8'h04, 8'h73);
    check(16'({ch2_slope, ch1_slope}), 16'h003b);
    wr(8'h04, 8'h07);
    check(16'({ch2_slope, ch1_slope}), 16'h0007);
    for (int m = 0; m < 4; m++) begin
      wr(8'h05, {2'h0, 2'(m), 4'hd});
      check(16'({spread_magnitude, spread_active}), 16'({2'(m), m != 0}));
    end
    wr(8'h05, 8'h3e);
    no_ticks(2);
    wr(8'h05, 8'h00);
    no_ticks(2);
    for (int r = 0; r < 16; r++) begin
      wr(8'h05, {4'h1, 4'(r)});
      if (r < 14) begin
        period(2, (r < 7) ? 4096 - 512 * r : 512 >> (r - 7));
      end else begin
        check(16'(spread_active), 16'h0000);
        no_ticks(2);
      end
    end
    for (int c = 1; c < 16; c++) begin
      wr(8'h06, {4'(c), 4'(c)});
      period(3, int'(ramp_tab[c - 1]));
      period(4, int'(ramp_tab[c - 1]));
    end
    wr(8'h06, 8'h00);
    no_ticks(3);
    no_ticks(4);
    for (int i = 0; i < 4; i++) begin
      wr(8'h07, cur_tab[i]);
      wr(8'h08, cur_tab[3 - i]);
      check(16'({ch1_code, ch2_code}), 16'({cur_tab[i], cur_tab[3 - i]}));
      check(16'({ch1_off, ch2_off}), 16'({cur_tab[i] <= 8'h08, cur_tab[3 - i] <= 8'h08}));
    end
    wr(8'h07, 8'h20);
    wr(8'h08, 8'h05);
    wr(8'h06, 8'h31);
    check(16'({ch2_code, ch2_off, ch1_off}), 16'h0016);
    period(4, 6);
    dual_phase_select = 1'b1;
    step();
    step();
    check(16'({ch2_code, ch2_off, ch1_off}), 16'h0080);
    period(4, 2);
    period(3, 2);
    dual_phase_select = 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(8'h09, 8'(c));
      period(5, c + 1);
    end
    wr(8'h0a, 8'ha5);
    wr(8'h0b, 8'hfe);
    check(16'(ch1_width), 16'h02a5);
    rd(8'h0b, 8'h02);
    wr(8'h0c, 8'h3c);
    wr(8'h0d, 8'h01);
    check(16'(ch2_width), 16'h013c);
    wr(8'h0e, 8'hff);
    rd(8'h0e, 8'h00);
    rd(8'h00, 8'h00);
    rd(8'hff, 8'h00);
    conclude();
  end
endmodule : dcr_config_regs_tb
